// ===== test/dqs_layer_model.sv
// dqdb layer model: collects delivered octets and timing marks
`timescale 1ns/1ps
module dqs_layer_model
	import dqs_pkg::*;
(
	// clock
	input wire logic               clk_sys,
	// sink side
	input wire dqs_pkg::dqs_out_t  slot_out,
	input wire logic               frame_timing_mark
);
	dqs_out_t got[$];
	int       marks = 0;
	always @(posedge clk_sys) begin
		if (slot_out.strobe)
			got.push_back(slot_out);
		if (frame_timing_mark)
			marks++;
	end
endmodule

// ===== test/dqs_sink_adapter_tb.sv
// self-checking bench of the slot sink adapter
`timescale 1ns/1ps
module dqs_sink_adapter_tb;
	import dqs_pkg::*;
	typedef struct packed {
		logic [3:0] ctrl;
		dqs_kind_t  k;
		logic [7:0] d;
		dqs_type_t  t;
		logic       v;
		logic [7:0] q;
		dqs_lss_t   c;
	} dqs_row_t;
	logic        clk_sys = '0, resetn = '0, tsf = '0;
	dqs_vc4_t    vc4 = '0;
	logic [7:0]  awa = '0, ara = '0, label;
	logic [31:0] wd = '0, rd, rdata;
	logic        awv = '0, wv = '0, arv = '0, br = '0, rr = '0, ce = 1'h1;
	logic [3:0]  ws = 4'hf;
	logic        aw_rdy, w_rdy, ar_rdy, b_vld, r_vld, ftm, link, sf, lmr, dlr;
	logic [1:0]  bresp, rresp, rs;
	dqs_out_t    slot_out;
	dqs_lss_t    code;
	int          errors = 0, checks_done = 0, cyc = 0, m0, n;
	dqs_row_t    rows[6] = '{
		'{4'h0, DQS_K_F2, 8'h3c, DQS_T_MGMT1, 1'h0, 8'hff, DQS_LSS_NOHOB},
		'{4'h1, DQS_K_F2, 8'h3c, DQS_T_MGMT1, 1'h0, 8'h3c, DQS_LSS_NOHOB},
		'{4'h1, DQS_K_F3, 8'ha5, DQS_T_MGMT2, 1'h0, 8'ha5, DQS_LSS_NOHOB},
		'{4'h5, DQS_K_F3, 8'ha5, DQS_T_MGMT2, 1'h1, 8'h00, DQS_LSS_DOWN},
		'{4'h7, DQS_K_F2, 8'h3c, DQS_T_MGMT1, 1'h1, 8'h00, DQS_LSS_DOWN},
		'{4'h3, DQS_K_F3, 8'h5a, DQS_T_MGMT2, 1'h0, 8'h5a, DQS_LSS_DOWN}
	};
	dqs_sink_adapter DUT (
		.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .vc4_in(vc4), .trail_signal_fail_in(tsf),
		.slot_out(slot_out), .frame_timing_mark(ftm), .link_state_out(link), .server_fail_out(sf),
		.outgoing_link_code(code), .label_mismatch_report(lmr), .delineation_loss_report(dlr),
		.accepted_label_out(label), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(aw_rdy),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(w_rdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(b_vld), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(ar_rdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_vld),
		.s_axi_rready(rr));
	dqs_layer_model model (.clk_sys(clk_sys), .slot_out(slot_out), .frame_timing_mark(ftm));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string what);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	task automatic put(input dqs_kind_t k, input logic [7:0] d, input logic f);
		vc4 <= '{1'h1, f, k, d};
		@(posedge clk_sys);
		vc4 <= '0;
		@(posedge clk_sys);
	endtask
	// holds each address and data channel until its own ready, and each response ready until its valid, is seen at the edge
	task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tr, p;
		p = 1'h1;
		if (w) begin
			awa <= a;
			wd <= d;
			awv <= 1'h1;
			wv <= 1'h1;
			br <= 1'h1;
		end else begin
			ara <= a;
			arv <= 1'h1;
			rr <= 1'h1;
		end
		while (p) begin
			@(negedge clk_sys);
			ta = w ? awv & aw_rdy : arv & ar_rdy;
			tw = wv & w_rdy;
			tr = w ? b_vld : r_vld;
			rd = rdata;
			rs = w ? bresp : rresp;
			@(posedge clk_sys);
			if (ta) begin
				awv <= 1'h0;
				arv <= 1'h0;
			end
			if (tw)
				wv <= 1'h0;
			if (tr) begin
				br <= 1'h0;
				rr <= 1'h0;
				p = 1'h0;
			end
		end
		// a spare edge keeps two calls from driving one signal in one step
		@(posedge clk_sys);
	endtask
	// ***************************************************************
	// tests
	// ***************************************************************
	initial begin
		wt(3);
		chk(slot_out, 12'h0ff, "reset octet");
		chk(code, DQS_LSS_DOWN, "reset code");
		wt(3);
		resetn <= 1'h1;
		wt(1);
		foreach (rows[i]) begin
			axi(1'h1, DQS_REG_CTRL, {28'h0, rows[i].ctrl});
			put(rows[i].k, rows[i].d, 1'h0);
			wt(3);
			chk(model.got[$], {1'h1, rows[i].t, rows[i].v, rows[i].q}, "octet");
			chk(code, rows[i].c, "code");
			chk(lmr, rows[i].ctrl[0], "mismatch");
			chk(link, 1'h0, "link");
		end
		axi(1'h0, DQS_REG_CTRL, '0);
		chk(rd, 32'h3, "ctrl");
		axi(1'h0, 8'h0c, '0);
		chk(rs, DQS_RESP_SLV, "unmapped");
		axi(1'h1, DQS_REG_CTRL, 32'h1);
		tsf <= 1'h1;
		wt(3);
		chk(lmr, 1'h0, "mismatch under tsf");
		chk(sf, 1'h1, "fail under tsf");
		tsf <= 1'h0;
		repeat (DQS_ACCEPT) put(DQS_K_C2, DQS_EXP_LABEL, 1'h0);
		wt(3);
		chk(label, DQS_EXP_LABEL, "label");
		chk(lmr, 1'h0, "mismatch");
		chk(dlr, 1'h1, "loss");
		m0 = model.marks;
		put(DQS_K_NONE, 8'h00, 1'h1);
		wt(2);
		chk(model.marks - m0, 1, "mark");
		for (int i = DQS_DELTA + 1; i >= 0; i--)
			put(DQS_K_H4, 8'((DQS_SLOT_LEN - DQS_SOI_STEP * i % DQS_SLOT_LEN) % DQS_SLOT_LEN), 1'h0);
		wt(3);
		chk(sf, 1'h0, "fail");
		chk(code, DQS_LSS_CONN, "code up");
		chk(link, 1'h1, "link up");
		axi(1'h0, DQS_REG_STATUS, '0);
		chk(rd, 32'h208, "status");
		put(DQS_K_F2, 8'h3c, 1'h0);
		wt(1);
		chk(model.got[$], {1'h1, DQS_T_MGMT1, 1'h1, 8'h3c}, "mgmt valid");
		// header octets raw except the check octet, which is xored with the coset; payload of ones descrambles to zero once 43 bits are in
		for (int i = 0; i < 59; i++)
			put(DQS_K_PAY, i % 53 < 5 ? 8'h11 : 8'hff, 1'h0);
		wt(2);
		n = model.got.size();
		chk(model.got[n - 59], {1'h1, DQS_T_START, 1'h1, 8'h11}, "first");
		chk(model.got[n - 55], {1'h1, DQS_T_BODY, 1'h1, 8'h44}, "check octet");
		chk(model.got[n - 7], 12'h900, "payload");
		chk(model.got[n - 1], 12'h900, "held state");
		put(DQS_K_H4, 8'hed, 1'h0);
		wt(3);
		chk(code, DQS_LSS_UP, "code");
		chk(link, 1'h0, "link");
		repeat (DQS_ALPHA) put(DQS_K_H4, 8'h3f, 1'h0);
		wt(3);
		chk(dlr, 1'h1, "loss");
		chk(code, DQS_LSS_NOHOB, "code");
		axi(1'h1, 8'h0c, '0);
		chk(rs, DQS_RESP_SLV, "write unmapped");
		ws <= 4'h0;
		axi(1'h1, DQS_REG_CTRL, 32'h8);
		chk(rs, DQS_RESP_OKAY, "masked write");
		ws <= 4'hf;
		axi(1'h0, DQS_REG_CTRL, '0);
		chk(rd, 32'h1, "masked ctrl");
		// octets offered with the enable low must not reach the layer
		n = model.got.size();
		ce <= 1'h0;
		put(DQS_K_F2, 8'h3c, 1'h0);
		ce <= 1'h1;
		wt(2);
		chk(model.got.size(), n, "frozen");
		// reset in mid-run, then header-check delineation from a clean window
		resetn <= 1'h0;
		wt(2);
		chk(slot_out, 12'h0ff, "reset octet again");
		chk(code, DQS_LSS_DOWN, "reset code again");
		chk(sf, 1'h1, "reset fail");
		resetn <= 1'h1;
		axi(1'h1, DQS_REG_CTRL, 32'h9);
		for (int i = 0; i < 7 * 53; i++)
			put(DQS_K_PAY, i % 53 == 4 ? 8'h55 : 8'h00, 1'h0);
		axi(1'h0, DQS_REG_STATUS, '0);
		chk(rd[9:8], DQS_SYNC, "check sync");
		end_of_test();
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
endmodule

// ===== verilog/dqs_pkg.sv
// shared constants, types and register map of the slot sink adapter
package dqs_pkg;
	// ***************************************************************
	// slot and overhead constants
	// ***************************************************************
	localparam logic [7:0]  DQS_EXP_LABEL  = 8'h14;
	localparam logic [7:0]  DQS_HCS_COSET  = 8'h55;
	localparam logic [7:0]  DQS_ALL_ONES   = 8'hff;
	localparam logic [7:0]  DQS_EMPTY      = 8'h00;
	localparam logic [5:0]  DQS_SLOT_LAST  = 6'h34;
	localparam logic [6:0]  DQS_SLOT_LEN   = 7'h35;
	localparam logic [6:0]  DQS_SOI_STEP   = 7'h2d;
	localparam logic [5:0]  DQS_HCS_POS    = 6'h04;
	localparam logic [5:0]  DQS_PAY_FIRST  = 6'h05;
	localparam int          DQS_DESCR_LEN  = 43;
	localparam logic [7:0]  DQS_CRC_POLY   = 8'h07;
	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int          DQS_FRAME_NS   = 125000;
	localparam int          DQS_CLK_NS     = 5;
	localparam int          DQS_FRAME_CYC  = DQS_FRAME_NS / DQS_CLK_NS;
	localparam int          DQS_ALPHA      = 7;
	localparam int          DQS_DELTA      = 6;
	localparam int          DQS_ACCEPT     = 5;
	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [7:0]  DQS_REG_CTRL   = 8'h00;
	localparam logic [7:0]  DQS_REG_STATUS = 8'h04;
	localparam logic [7:0]  DQS_REG_LABEL  = 8'h08;
	localparam logic [3:0]  DQS_CTRL_RST   = 4'h0;
	localparam int          DQS_CTRL_ACT   = 0;
	localparam int          DQS_CTRL_FORCE = 1;
	localparam int          DQS_CTRL_HOB   = 2;
	localparam int          DQS_CTRL_MODE  = 3;
	localparam logic [1:0]  DQS_RESP_OKAY  = 2'b00;
	localparam logic [1:0]  DQS_RESP_SLV   = 2'b10;
	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [2:0] {
		DQS_K_NONE = 3'b000, DQS_K_PAY = 3'b001, DQS_K_C2 = 3'b010,
		DQS_K_H4 = 3'b011, DQS_K_F2 = 3'b100, DQS_K_F3 = 3'b101
	} dqs_kind_t;
	typedef enum logic [1:0] {
		DQS_T_BODY = 2'b00, DQS_T_START = 2'b01, DQS_T_MGMT1 = 2'b10, DQS_T_MGMT2 = 2'b11
	} dqs_type_t;
	typedef enum logic [1:0] {
		DQS_LSS_CONN = 2'b00, DQS_LSS_UP = 2'b01, DQS_LSS_NOHOB = 2'b10, DQS_LSS_DOWN = 2'b11
	} dqs_lss_t;
	typedef enum logic [1:0] {
		DQS_HUNT = 2'b00, DQS_PRESYNC = 2'b01, DQS_SYNC = 2'b10
	} dqs_dstate_t;
	typedef struct packed {
		logic       strobe;
		logic       fs;
		dqs_kind_t  kind;
		logic [7:0] data;
	} dqs_vc4_t;
	typedef struct packed {
		logic       strobe;
		dqs_type_t  octet_type_mark;
		logic       octet_valid_mark;
		logic [7:0] data;
	} dqs_out_t;
endpackage

// ===== verilog/dqs_sink_adapter.sv
// slot sink adapter: delineation, descrambling, link status and register slave
`timescale 1ns/1ps
module dqs_sink_adapter
	import dqs_pkg::*;
#(
	parameter int FRAME_CYCLES = dqs_pkg::DQS_FRAME_CYC,
	parameter int ALPHA        = dqs_pkg::DQS_ALPHA,
	parameter int DELTA        = dqs_pkg::DQS_DELTA,
	parameter int ACCEPT       = dqs_pkg::DQS_ACCEPT
) (
	// clock, reset, enable
	input  wire logic               clk_sys,
	input  wire logic               resetn,
	input  wire logic               ce,
	// vc-4 side
	input  wire dqs_pkg::dqs_vc4_t  vc4_in,
	input  wire logic               trail_signal_fail_in,
	// dqdb layer side
	output dqs_pkg::dqs_out_t       slot_out,
	output logic                    frame_timing_mark,
	output logic                    link_state_out,
	output logic                    server_fail_out,
	output dqs_pkg::dqs_lss_t       outgoing_link_code,
	// management
	output logic                    label_mismatch_report,
	output logic                    delineation_loss_report,
	output logic [7:0]              accepted_label_out,
	// axi4-lite slave
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready
);
	import dqs_pkg::*;

	// ***************************************************************
	// functions
	// ***************************************************************
	function automatic logic [7:0] dqs_crc8(input logic [23:0] hdr);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			fb = c[7] ^ hdr[i];
			c = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ DQS_CRC_POLY;
			end
		end
		return c;
	endfunction

	// returns {next state, descrambled octet}, msb received first
	function automatic logic [DQS_DESCR_LEN+7:0] dqs_descr(input logic [DQS_DESCR_LEN-1:0] sr_in,
		input logic [7:0] d);
		logic [DQS_DESCR_LEN-1:0] sr;
		logic [7:0]               o;
		sr = sr_in;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			o[i] = d[i] ^ sr[DQS_DESCR_LEN-1];
			sr = {sr[DQS_DESCR_LEN-2:0], d[i]};
		end
		return {sr, o};
	endfunction

	function automatic logic [5:0] dqs_soi_next(input logic [5:0] s);
		logic [6:0] t;
		t = {1'b0, s} + DQS_SOI_STEP;
		if (t >= DQS_SLOT_LEN) begin
			t = t - DQS_SLOT_LEN;
		end
		return t[5:0];
	endfunction

	// ***************************************************************
	// control register and decode of the incoming octet
	// ***************************************************************
	logic [3:0]  ctrl;
	logic        act, force_link_down, head_of_bus_capable, mode_hcs, mode_q;
	logic        pay, h4_oct, c2_oct, f2_oct, f3_oct;
	logic [5:0]  soi;
	logic [1:0]  link_status_code;
	assign act                 = ctrl[DQS_CTRL_ACT];
	assign force_link_down     = ctrl[DQS_CTRL_FORCE];
	assign head_of_bus_capable = ctrl[DQS_CTRL_HOB];
	assign mode_hcs            = ctrl[DQS_CTRL_MODE];
	assign pay    = ce & vc4_in.strobe & (vc4_in.kind == DQS_K_PAY);
	assign h4_oct = ce & vc4_in.strobe & (vc4_in.kind == DQS_K_H4);
	assign c2_oct = ce & vc4_in.strobe & (vc4_in.kind == DQS_K_C2);
	assign f2_oct = ce & vc4_in.strobe & (vc4_in.kind == DQS_K_F2);
	assign f3_oct = ce & vc4_in.strobe & (vc4_in.kind == DQS_K_F3);
	assign soi    = vc4_in.data[5:0];

	// ***************************************************************
	// delineation
	// ***************************************************************
	dqs_dstate_t dstate;
	logic [3:0]  chk_cnt;
	logic [5:0]  pos, exp_soi;
	logic [23:0] hdr_win;
	logic        hcs_ev, hcs_ok, h4_ev, h4_ok, soi_valid, ev, ok;
	logic        delineation_loss_defect;
	assign hcs_ok    = (dqs_crc8(hdr_win) == (vc4_in.data ^ DQS_HCS_COSET));
	assign hcs_ev    = pay & mode_hcs & ((dstate == DQS_HUNT) | (pos == DQS_HCS_POS));
	assign soi_valid = (soi <= DQS_SLOT_LAST);
	assign h4_ev     = h4_oct & ~mode_hcs;
	assign h4_ok     = soi_valid & ((dstate == DQS_HUNT) | (soi == exp_soi));
	assign ev        = mode_hcs ? hcs_ev : h4_ev;
	assign ok        = mode_hcs ? hcs_ok : h4_ok;
	assign delineation_loss_defect = (dstate != DQS_SYNC);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dstate <= DQS_HUNT;
			chk_cnt <= 4'h0;
			mode_q <= 1'b0;
		end else if (ce) begin
			mode_q <= mode_hcs;
			if (mode_q != mode_hcs) begin
				dstate <= DQS_HUNT;
				chk_cnt <= 4'h0;
			end else if (ev) begin
				case (dstate)
					DQS_HUNT: begin
						if (ok) begin
							dstate <= DQS_PRESYNC;
						end
						chk_cnt <= 4'h0;
					end
					DQS_PRESYNC: begin
						if (!ok) begin
							dstate <= DQS_HUNT;
							chk_cnt <= 4'h0;
						end else if (chk_cnt == 4'(DELTA - 1)) begin
							dstate <= DQS_SYNC;
							chk_cnt <= 4'h0;
						end else begin
							chk_cnt <= chk_cnt + 4'h1;
						end
					end
					DQS_SYNC: begin
						if (ok) begin
							chk_cnt <= 4'h0;
						end else if (chk_cnt == 4'(ALPHA - 1)) begin
							dstate <= DQS_HUNT;
							chk_cnt <= 4'h0;
						end else begin
							chk_cnt <= chk_cnt + 4'h1;
						end
					end
					default: begin
						dstate <= DQS_HUNT;
						chk_cnt <= 4'h0;
					end
				endcase
			end
		end
	end

	// slot position of the next payload octet
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pos <= 6'h00;
			exp_soi <= 6'h00;
			hdr_win <= 24'h000000;
		end else begin
			if (pay) begin
				hdr_win <= {hdr_win[15:0], vc4_in.data};
				if (mode_hcs && dstate == DQS_HUNT && hcs_ok) begin
					pos <= DQS_PAY_FIRST;
				end else begin
					pos <= (pos == DQS_SLOT_LAST) ? 6'h00 : pos + 6'h01;
				end
			end
			if (h4_ev) begin
				exp_soi <= soi_valid ? dqs_soi_next(soi) : dqs_soi_next(exp_soi);
				if (h4_ok) begin
					pos <= (soi == 6'h00) ? 6'h00 : 6'(DQS_SLOT_LEN - {1'b0, soi});
				end
			end
		end
	end

	// ***************************************************************
	// descrambler
	// ***************************************************************
	logic [DQS_DESCR_LEN-1:0] descr_sr;
	logic [DQS_DESCR_LEN+7:0] descr_res;
	logic                     in_payload;
	assign descr_res  = dqs_descr(descr_sr, vc4_in.data);
	assign in_payload = pay & (dstate != DQS_HUNT) & (pos >= DQS_PAY_FIRST);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			descr_sr <= '0;
		end else if (in_payload) begin
			descr_sr <= descr_res[DQS_DESCR_LEN+7:8];
		end
	end

	// ***************************************************************
	// signal label, incoming link code, timing mark
	// ***************************************************************
	logic [7:0]  label_cand;
	logic [2:0]  label_cnt;
	logic        label_mismatch_defect;
	logic [19:0] frame_cnt;
	assign label_mismatch_defect = (accepted_label_out != DQS_EXP_LABEL);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			label_cand <= 8'h00;
			label_cnt <= 3'h0;
			accepted_label_out <= 8'h00;
		end else if (c2_oct) begin
			if (vc4_in.data != label_cand) begin
				label_cand <= vc4_in.data;
				label_cnt <= 3'h0;
			end else if (label_cnt == 3'(ACCEPT - 2)) begin
				accepted_label_out <= label_cand;
			end else begin
				label_cnt <= label_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			link_status_code <= DQS_LSS_DOWN;
		end else if (h4_oct) begin
			link_status_code <= vc4_in.data[7:6];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			frame_cnt <= 20'h00000;
			frame_timing_mark <= 1'b0;
		end else if (ce) begin
			if ((vc4_in.strobe && vc4_in.fs) || frame_cnt == 20'(FRAME_CYCLES - 1)) begin
				frame_cnt <= 20'h00000;
				frame_timing_mark <= 1'b1;
			end else begin
				frame_cnt <= frame_cnt + 20'h00001;
				frame_timing_mark <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// consequent actions and link status table
	// ***************************************************************
	logic     server_signal_fail, next_link_up;
	dqs_lss_t next_code;
	assign server_signal_fail = trail_signal_fail_in | label_mismatch_defect | delineation_loss_defect;

	always_comb begin
		next_link_up = 1'b0;
		next_code = DQS_LSS_DOWN;
		if (force_link_down) begin
			next_code = DQS_LSS_DOWN;
		end else if (server_signal_fail) begin
			next_code = head_of_bus_capable ? DQS_LSS_DOWN : DQS_LSS_NOHOB;
		end else if (link_status_code == DQS_LSS_CONN) begin
			next_link_up = 1'b1;
			next_code = DQS_LSS_CONN;
		end else if (link_status_code == DQS_LSS_UP) begin
			next_code = DQS_LSS_CONN;
		end else begin
			next_code = DQS_LSS_UP;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			link_state_out <= 1'b0;
			server_fail_out <= 1'b1;
			outgoing_link_code <= DQS_LSS_DOWN;
			label_mismatch_report <= 1'b0;
			delineation_loss_report <= 1'b0;
		end else if (ce) begin
			link_state_out <= next_link_up;
			server_fail_out <= server_signal_fail;
			outgoing_link_code <= next_code;
			label_mismatch_report <= act & label_mismatch_defect & ~trail_signal_fail_in;
			delineation_loss_report <= act & delineation_loss_defect & ~trail_signal_fail_in
				& ~label_mismatch_defect;
		end
	end

	// ***************************************************************
	// output octet stream
	// ***************************************************************
	logic [7:0] raw;
	dqs_type_t  next_type;
	assign raw = (pay && pos == DQS_HCS_POS) ? (vc4_in.data ^ DQS_HCS_COSET)
		: (in_payload ? descr_res[7:0] : vc4_in.data);
	assign next_type = f2_oct ? DQS_T_MGMT1 : (f3_oct ? DQS_T_MGMT2
		: ((pos == 6'h00) ? DQS_T_START : DQS_T_BODY));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			slot_out <= '{strobe: 1'b0, octet_type_mark: DQS_T_BODY, octet_valid_mark: 1'b0, data: DQS_ALL_ONES};
		end else if (ce) begin
			slot_out.strobe <= pay | f2_oct | f3_oct;
			if (pay || f2_oct || f3_oct) begin
				slot_out.octet_type_mark <= next_type;
				if (!act) begin
					slot_out.data <= DQS_ALL_ONES;
					slot_out.octet_valid_mark <= 1'b0;
				end else if (server_signal_fail && head_of_bus_capable) begin
					slot_out.data <= DQS_EMPTY;
					slot_out.octet_valid_mark <= 1'b1;
				end else begin
					slot_out.data <= raw;
					slot_out.octet_valid_mark <= ~server_signal_fail;
				end
			end
		end
	end

	// ***************************************************************
	// axi4-lite slave
	// ***************************************************************
	logic       aw_held, w_held;
	logic [7:0] aw_addr;
	logic [7:0] w_byte;
	logic       w_lane;
	assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ce & ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ce & ~s_axi_rvalid;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			ctrl <= DQS_CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DQS_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
			end
			if (aw_held && w_held) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if ({aw_addr[7:2], 2'b00} == DQS_REG_CTRL) begin
					s_axi_bresp <= DQS_RESP_OKAY;
					if (w_lane) begin
						ctrl <= w_byte[3:0];
					end
				end else if ({aw_addr[7:2], 2'b00} == DQS_REG_STATUS
					|| {aw_addr[7:2], 2'b00} == DQS_REG_LABEL) begin
					s_axi_bresp <= DQS_RESP_OKAY;
				end else begin
					s_axi_bresp <= DQS_RESP_SLV;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= DQS_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= DQS_RESP_OKAY;
				case ({s_axi_araddr[7:2], 2'b00})
					DQS_REG_CTRL:   s_axi_rdata <= {28'h0000000, ctrl};
					DQS_REG_STATUS: s_axi_rdata <= {22'h000000, dstate, outgoing_link_code,
						link_status_code, link_state_out, server_fail_out,
						delineation_loss_report, label_mismatch_report};
					DQS_REG_LABEL:  s_axi_rdata <= {24'h000000, accepted_label_out};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= DQS_RESP_SLV;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	soi_range_a: assert property (h4_ev && dstate == DQS_SYNC && !soi_valid && chk_cnt == 4'h0 && mode_q == mode_hcs
		|=> chk_cnt == 4'h1) else $error("bad offset not counted as unexpected");
	soi_step_a: assert property (h4_ev && soi_valid |=> exp_soi == 6'((int'($past(soi)) + 45) % 53))
		else $error("expected offset did not step by 45 mod 53");
	hcs_coset_a: assert property (pay && act && !server_signal_fail && pos == DQS_HCS_POS
		|=> slot_out.data == ($past(vc4_in.data) ^ 8'h55)) else $error("check octet not xored");
	descr_hold_a: assert property (!in_payload |=> $stable(descr_sr))
		else $error("descrambler moved outside payload");
	inactive_ones_a: assert property ((pay || f2_oct) && !act |=> slot_out.data == 8'hff && !label_mismatch_report)
		else $error("inactive output not all ones");
	ssf_down_a: assert property (ce && server_signal_fail |=> !link_state_out && server_fail_out)
		else $error("link up during server fail");
	force_down_a: assert property (ce && force_link_down |=> outgoing_link_code == DQS_LSS_DOWN)
		else $error("forced down not sent");
	nohob_code_a: assert property (ce && server_signal_fail && !force_link_down && !head_of_bus_capable
		|=> outgoing_link_code == DQS_LSS_NOHOB && (!slot_out.strobe || !slot_out.octet_valid_mark))
		else $error("no head-of-bus code missing");
	mgmt_pass_a: assert property (f2_oct && act && !server_signal_fail
		|=> slot_out.data == $past(vc4_in.data) && slot_out.octet_type_mark == DQS_T_MGMT1)
		else $error("management octet altered");

	sync_reached_c: cover property (dstate == DQS_PRESYNC ##1 dstate == DQS_SYNC);
	label_ok_c: cover property ($rose(!label_mismatch_defect));
	valid_slot_c: cover property (slot_out.strobe && slot_out.octet_valid_mark
		&& slot_out.octet_type_mark == DQS_T_START);
endmodule
